// ---- hdl/adc_ctrl_pkg.sv ----
/*
 Shared constants and types of the converter start and trigger control.
 Assumes a 32-bit APB master and one system clock.
*/
package adc_ctrl_pkg;
  // Printed offsets are register indices; byte address is four times each
  localparam logic [7:0] MODE_INDEX = 8'hc4;
  localparam logic [7:0] START_INDEX = 8'hc6;
  localparam logic [7:0] RESULT_INDEX = 8'hc5;
  localparam int ADDR_WIDTH = 12;
  localparam logic [7:0] MODE_RESET = 8'h30;
  localparam logic [7:0] START_RESET = 8'h7f;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] SAR_START = 8'h80;
  localparam int PERIOD_SEL_BIT = 7;
  localparam int TRIG_EN_BIT = 6;
  localparam int FLAG_BIT = 7;
  localparam logic [5:0] PERIOD_LONG = 6'h3e;
  localparam logic [5:0] PERIOD_SHORT = 6'h1f;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MIN_CONV_NS = 12400;
  localparam int MIN_CONV_CYCLES = (MIN_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [0:0]
  {
    IDLE = 1'b0,
    CONVERT = 1'b1
  } conv_state_type;

  typedef struct packed
  {
    logic sel;
    logic enable;
    logic write;
    logic [ADDR_WIDTH-1:0] addr;
    logic [31:0] wdata;
  } apb_req_type;
endpackage

// ---- hdl/adc_start_trigger_control.sv ----
/*
 Start, trigger and timing control of an 8-bit successive-approximation
 converter, with its mode, start/status and result registers on APB.
 Assumes an external comparator and DAC: COMP_IN is high when the selected
 analog input is at or above DAC_CODE. COMP_IN and EXT_TRIGGER_PIN are
 asynchronous pins.
*/
//
// Contract
// - Trigger disabled: pin edges start nothing
// - Trigger enabled: either pin edge starts conversion
// - Period 62 cycles, or 31 when selected
// - Flag write 1 starts, 0 stops
// - Flag reads 0 after conversion completes
`timescale 1ns/1ps

module adc_start_trigger_control
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [adc_ctrl_pkg::ADDR_WIDTH-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_TRIGGER_PIN,
  input wire logic COMP_IN,
  output logic [3:0] CHANNEL_SEL,
  output logic [7:0] DAC_CODE,
  output logic CONV_BUSY
);

////////////////////////////////////////////////////////////////////////////////
// Bus decode

adc_ctrl_pkg::apb_req_type req;
assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};

wire access_phase = req.sel && req.enable;
wire commit = access_phase && PREADY;
wire hit_mode = req.addr == {2'h0, adc_ctrl_pkg::MODE_INDEX, 2'h0};
wire hit_start = req.addr == {2'h0, adc_ctrl_pkg::START_INDEX, 2'h0};
wire hit_result = req.addr == {2'h0, adc_ctrl_pkg::RESULT_INDEX, 2'h0};
wire hit_any = hit_mode || hit_start || hit_result;
wire write_mode = commit && req.write && hit_mode;
wire write_start = commit && req.write && hit_start;
wire sw_start = write_start && req.wdata[adc_ctrl_pkg::FLAG_BIT];
wire sw_stop = write_start && !req.wdata[adc_ctrl_pkg::FLAG_BIT];

////////////////////////////////////////////////////////////////////////////////
// Registers and state

logic [7:0] mode;
logic [7:0] result;
logic [7:0] sar;
logic [2:0] bit_pos;
logic bits_left;
logic [5:0] period_len;
logic [5:0] cycle_cnt;
logic [2:0] step_cnt;
adc_ctrl_pkg::conv_state_type state;
adc_ctrl_pkg::conv_state_type next_state;
logic trig_meta;
logic trig_sync;
logic trig_prev;
logic comp_meta;
logic comp_sync;

wire trig_en = mode[adc_ctrl_pkg::TRIG_EN_BIT];
wire period_sel = mode[adc_ctrl_pkg::PERIOD_SEL_BIT];
wire conv_active = state == adc_ctrl_pkg::CONVERT;

////////////////////////////////////////////////////////////////////////////////
// Trigger and comparator pins

// Two stages before the edge detector; only the second stage is compared
always_ff @(posedge CLK)
begin
  if (SYS_RST)
  begin
    trig_meta <= 1'b0;
    trig_sync <= 1'b0;
    trig_prev <= 1'b0;
    comp_meta <= 1'b0;
    comp_sync <= 1'b0;
  end
  else
  begin
    trig_meta <= EXT_TRIGGER_PIN;
    trig_sync <= trig_meta;
    trig_prev <= trig_sync;
    comp_meta <= COMP_IN;
    comp_sync <= comp_meta;
  end
end

wire trig_edge = trig_sync ^ trig_prev;
wire hw_start = trig_edge && trig_en;

////////////////////////////////////////////////////////////////////////////////
// Sequencing

// Starts while converting are ignored; a stop in the same cycle wins
wire start_req = (sw_start || hw_start) && !conv_active && !sw_stop;
wire step_len_end = step_cnt == (period_len[5:3] - 3'h1);
wire conv_done = conv_active && !sw_stop && cycle_cnt == period_len - 6'h1;
wire [5:0] start_len = period_sel ? adc_ctrl_pkg::PERIOD_SHORT : adc_ctrl_pkg::PERIOD_LONG;

always_comb
begin
  next_state = state;
  case (state)
    adc_ctrl_pkg::IDLE:
    begin
      if (start_req)
        next_state = adc_ctrl_pkg::CONVERT;
    end
    adc_ctrl_pkg::CONVERT:
    begin
      if (sw_stop || conv_done)
        next_state = adc_ctrl_pkg::IDLE;
    end
    default:
      next_state = adc_ctrl_pkg::IDLE;
  endcase
end

always_ff @(posedge CLK)
begin
  if (SYS_RST)
    state <= adc_ctrl_pkg::IDLE;
  else
    state <= next_state;
end

////////////////////////////////////////////////////////////////////////////////
// Successive approximation

// Period latched at start so a mode write cannot stretch a running conversion
always_ff @(posedge CLK)
begin
  if (SYS_RST)
  begin
    period_len <= adc_ctrl_pkg::PERIOD_LONG;
    cycle_cnt <= 6'h00;
    step_cnt <= 3'h0;
    bit_pos <= 3'h7;
    bits_left <= 1'b0;
    sar <= adc_ctrl_pkg::SAR_START;
  end
  else if (start_req)
  begin
    period_len <= start_len;
    cycle_cnt <= 6'h00;
    step_cnt <= 3'h0;
    bit_pos <= 3'h7;
    bits_left <= 1'b1;
    sar <= adc_ctrl_pkg::SAR_START;
  end
  else if (conv_active)
  begin
    cycle_cnt <= cycle_cnt + 6'h01;
    step_cnt <= step_len_end ? 3'h0 : step_cnt + 3'h1;
    if (step_len_end && bits_left)
    begin
      sar[bit_pos] <= comp_sync;
      if (bit_pos != 3'h0)
        sar[bit_pos - 3'h1] <= 1'b1;
      bit_pos <= bit_pos - 3'h1;
      bits_left <= bit_pos != 3'h0;
    end
  end
end

always_ff @(posedge CLK)
begin
  if (SYS_RST)
    result <= adc_ctrl_pkg::RESULT_RESET;
  else if (conv_done)
    result <= sar;
end

always_ff @(posedge CLK)
begin
  if (SYS_RST)
    mode <= adc_ctrl_pkg::MODE_RESET;
  else if (write_mode)
    mode <= {req.wdata[7:6], 2'h3, req.wdata[3:0]};
end

////////////////////////////////////////////////////////////////////////////////
// Bus answer and pins

// One wait state: ready rises in the second access cycle
wire [7:0] status_read = {conv_active, adc_ctrl_pkg::START_RESET[6:0]};
wire [7:0] read_byte = hit_mode ? mode : (hit_start ? status_read : (hit_result ? result : 8'h00));

// Trial code leaves straight from the SAR flops: a further register would leave
// the short period's 3-cycle step one comparator sample short
assign DAC_CODE = sar;

always_ff @(posedge CLK)
begin
  if (SYS_RST)
  begin
    PREADY <= 1'b0;
    PSLVERR <= 1'b0;
    PRDATA <= 32'h00000000;
    CHANNEL_SEL <= 4'h0;
    CONV_BUSY <= 1'b0;
  end
  else
  begin
    PREADY <= access_phase && !PREADY;
    PSLVERR <= access_phase && !PREADY && !hit_any;
    PRDATA <= {24'h000000, read_byte};
    CHANNEL_SEL <= mode[3:0];
    CONV_BUSY <= next_state == adc_ctrl_pkg::CONVERT;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Checks

sequence s_idle_edge;
  !conv_active && trig_edge && !sw_start && !sw_stop;
endsequence

property p_trig_ignored;
  @(posedge CLK) disable iff (SYS_RST)
  s_idle_edge and !trig_en |=> !conv_active;
endproperty
a_trig_ignored: assert property (p_trig_ignored) else $error("Trigger started while disabled");

property p_trig_starts;
  @(posedge CLK) disable iff (SYS_RST)
  s_idle_edge and trig_en |=> conv_active ##1 CONV_BUSY;
endproperty
a_trig_starts: assert property (p_trig_starts) else $error("Enabled trigger edge missed");

property p_period_len;
  @(posedge CLK) disable iff (SYS_RST)
  conv_done |-> cycle_cnt == period_len - 6'h1 &&
    (period_len == adc_ctrl_pkg::PERIOD_LONG || period_len == adc_ctrl_pkg::PERIOD_SHORT);
endproperty
a_period_len: assert property (p_period_len) else $error("Conversion period wrong");

property p_period_pick;
  @(posedge CLK) disable iff (SYS_RST)
  start_req |=> period_len == (($past(period_sel)) ? adc_ctrl_pkg::PERIOD_SHORT : adc_ctrl_pkg::PERIOD_LONG);
endproperty
a_period_pick: assert property (p_period_pick) else $error("Period select ignored");

property p_sw_start;
  @(posedge CLK) disable iff (SYS_RST)
  sw_start && !conv_active |=> conv_active && CONV_BUSY ##1 (PRDATA[7] || !$past(hit_start));
endproperty
a_sw_start: assert property (p_sw_start) else $error("Write of one did not start");

property p_sw_stop;
  @(posedge CLK) disable iff (SYS_RST)
  sw_stop |=> !conv_active && !CONV_BUSY;
endproperty
a_sw_stop: assert property (p_sw_stop) else $error("Write of zero did not stop");

property p_done_clears;
  @(posedge CLK) disable iff (SYS_RST)
  conv_done |=> !conv_active;
endproperty
a_done_clears: assert property (p_done_clears) else $error("Flag not cleared at completion");

property p_result_load;
  @(posedge CLK) disable iff (SYS_RST)
  conv_done |=> result == $past(sar) && !status_read[7];
endproperty
a_result_load: assert property (p_result_load) else $error("Result not loaded with flag clear");

property p_stop_keeps;
  @(posedge CLK) disable iff (SYS_RST)
  conv_active && sw_stop |=> !conv_active && result == $past(result);
endproperty
a_stop_keeps: assert property (p_stop_keeps) else $error("Stop write loaded a result");

property p_flag_read;
  @(posedge CLK) disable iff (SYS_RST)
  access_phase && !PREADY && hit_start |=> PRDATA[7] == $past(conv_active) && PREADY;
endproperty
a_flag_read: assert property (p_flag_read) else $error("Status flag read wrong");

property p_result_hold;
  @(posedge CLK) disable iff (SYS_RST)
  !conv_done |=> result == $past(result);
endproperty
a_result_hold: assert property (p_result_hold) else $error("Result changed outside completion");

property p_busy_flag;
  @(posedge CLK) disable iff (SYS_RST)
  CONV_BUSY == conv_active;
endproperty
a_busy_flag: assert property (p_busy_flag) else $error("Busy pin differs from flag");

endmodule

// ---- verif/analog_side.sv ----
/*
 Analog far side: an ideal comparator of one input level against the trial code.
 Assumes the bench changes the level only while no conversion runs.
*/
`timescale 1ns/1ps

module analog_side
(
  input wire logic [7:0] dac_code,
  input wire logic [7:0] level,
  output logic comp_in
);
  // No noise or offset, so the ideal result equals the level
  assign comp_in = (level >= dac_code);
endmodule

// ---- verif/testbench.sv ----
/*
 Self-checking bench of the converter control: APB master, analog model, checks.
 Assumes the design package and the analog side model are compiled first.
*/
`timescale 1ns/1ps

module testbench;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic EXT_TRIGGER_PIN = 1'b0;
  logic [7:0] level = 8'h00;
  logic [31:0] PRDATA, rd;
  logic PREADY, PSLVERR, COMP_IN, CONV_BUSY, err;
  logic [3:0] CHANNEL_SEL;
  logic [7:0] DAC_CODE, res_m;
  logic [31:0] seed = 32'h12104b65;
  int failures = 0, n_tests = 0, cycles = 0, n;

  always #20 CLK = ~CLK;

  adc_start_trigger_control i_dut (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .EXT_TRIGGER_PIN(EXT_TRIGGER_PIN), .COMP_IN(COMP_IN),
    .CHANNEL_SEL(CHANNEL_SEL), .DAC_CODE(DAC_CODE), .CONV_BUSY(CONV_BUSY));
  analog_side i_analog (.dac_code(DAC_CODE), .level(level), .comp_in(COMP_IN));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Printed offsets are word indices; request stands until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= {2'b00, idx, 2'b00};
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Busy length, final trial code, then flag and result as seen by software
  task automatic conv(input int period);
    n = 0;
    @(negedge CLK);
    while (CONV_BUSY !== 1'b1) @(negedge CLK);
    while (CONV_BUSY === 1'b1)
    begin
      n++;
      @(negedge CLK);
    end
    chk(n, period);
    chk({24'h0, DAC_CODE}, {24'h0, res_m});
    apb(1'b0, adc_ctrl_pkg::START_INDEX, 8'h00);
    chk(rd, 32'h7f);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, adc_ctrl_pkg::RESULT_INDEX, 8'h00);
    chk(rd, {24'h0, res_m});
  endtask

  task automatic results;
    $display("failures %0d, n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      failures++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge CLK);
    SYS_RST <= 1'b0;
    apb(1'b0, adc_ctrl_pkg::MODE_INDEX, 8'h00);
    chk(rd, 32'h30);
    apb(1'b0, adc_ctrl_pkg::START_INDEX, 8'h00);
    chk(rd, 32'h7f);
    apb(1'b0, adc_ctrl_pkg::RESULT_INDEX, 8'h00);
    chk(rd, 32'h00);
    apb(1'b0, 8'hc7, 8'h00);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      level <= seed[7:0];
      res_m = seed[7:0];
      // Bench clock outruns the minimum conversion time; only the logic is checked
      apb(1'b1, adc_ctrl_pkg::MODE_INDEX, {i[0], 3'b000, seed[11:8]});
      repeat (2) @(negedge CLK);
      chk({28'h0, CHANNEL_SEL}, {28'h0, seed[11:8]});
      apb(1'b0, adc_ctrl_pkg::MODE_INDEX, 8'h00);
      chk(rd, {24'h0, i[0], 3'b011, seed[11:8]});
      apb(1'b1, adc_ctrl_pkg::START_INDEX, 8'h80);
      conv(i[0] ? 31 : 62);
    end
    // Stop mid-run: flag drops, result keeps the old value
    level <= ~res_m;
    apb(1'b1, adc_ctrl_pkg::START_INDEX, 8'h80);
    apb(1'b0, adc_ctrl_pkg::START_INDEX, 8'h00);
    chk(rd, 32'hff);
    apb(1'b1, adc_ctrl_pkg::START_INDEX, 8'h00);
    @(negedge CLK);
    @(negedge CLK);
    chk({31'h0, CONV_BUSY}, 32'h0);
    apb(1'b1, adc_ctrl_pkg::RESULT_INDEX, 8'h5a);
    apb(1'b0, adc_ctrl_pkg::RESULT_INDEX, 8'h00);
    chk(rd, {24'h0, res_m});
    // Pin edges with the trigger off
    apb(1'b1, adc_ctrl_pkg::MODE_INDEX, 8'h00);
    EXT_TRIGGER_PIN <= 1'b1;
    repeat (4) @(posedge CLK);
    EXT_TRIGGER_PIN <= 1'b0;
    repeat (8) @(negedge CLK);
    chk({31'h0, CONV_BUSY}, 32'h0);
    // Both pin edges with the trigger on
    apb(1'b1, adc_ctrl_pkg::MODE_INDEX, 8'h40);
    for (int i = 0; i < 2; i++)
    begin
      seed = xs(seed);
      level <= seed[7:0];
      res_m = seed[7:0];
      @(posedge CLK);
      EXT_TRIGGER_PIN <= ~i[0];
      conv(62);
    end
    results();
  end
endmodule
